// *** src/fcs_consts.svh ***
// Purpose: Timing counts, command words and bit positions for the flash host
// Assumes: 40 MHz clock; word-wide parallel flash with a JEDEC command set
// Notes:   Definitions only
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and bus timing
// ----------------------------------------------------------------
`define FCS_CLK_NS        25
`define FCS_T_RANDOM_NS   55
`define FCS_T_PAGE_NS     20
`define FCS_T_WE_NS       35
`define FCS_T_RESET_NS    500
// Least times round up to whole cycles
`define FCS_CYC_UP(t)     ((((t) + `FCS_CLK_NS - 1) / `FCS_CLK_NS) < 1 ? 1 : \
                           (((t) + `FCS_CLK_NS - 1) / `FCS_CLK_NS))
`define FCS_RANDOM_CYC    `FCS_CYC_UP(`FCS_T_RANDOM_NS)
`define FCS_PAGE_CYC      `FCS_CYC_UP(`FCS_T_PAGE_NS)
`define FCS_WE_CYC        `FCS_CYC_UP(`FCS_T_WE_NS)
`define FCS_RESET_CYC     `FCS_CYC_UP(`FCS_T_RESET_NS)
`define FCS_SYNC_CYC      3

// ----------------------------------------------------------------
// Array layout and status bits
// ----------------------------------------------------------------
`define FCS_PAGE_BITS     3
`define FCS_BANK_BITS     2
`define FCS_POLL_BIT      7
`define FCS_TOGGLE_BIT    6

// ----------------------------------------------------------------
// Command addresses and data words
// ----------------------------------------------------------------
`define FCS_UNLOCK_A1     12'h555
`define FCS_UNLOCK_A2     12'h2AA
`define FCS_D_UNLOCK1     16'h00AA
`define FCS_D_UNLOCK2     16'h0055
`define FCS_D_PROGRAM     16'h00A0
`define FCS_D_ERASE_SETUP 16'h0080
`define FCS_D_SECTOR_ERS  16'h0030
`define FCS_D_SUSPEND     16'h00B0
`define FCS_D_RESUME      16'h0030
`define FCS_D_RESET       16'h00F0
`define FCS_D_BYPASS      16'h0020
`define FCS_D_OTP_ENTER   16'h0088
`define FCS_D_EXIT1       16'h0090
`define FCS_D_EXIT2       16'h0000

`endif

// *** src/fcs_pkg.sv ***
// Purpose: Types shared by the flash host modules
// Assumes: Nothing beyond the consts header
// Notes:   One-hot state codes
package fcs_pkg;
   typedef enum logic [3:0] {
      FCS_OP_READ         = 4'h0,
      FCS_OP_PROGRAM      = 4'h1,
      FCS_OP_ERASE        = 4'h2,
      FCS_OP_SUSPEND      = 4'h3,
      FCS_OP_RESUME       = 4'h4,
      FCS_OP_RESET        = 4'h5,
      FCS_OP_BYPASS_ENTER = 4'h6,
      FCS_OP_BYPASS_EXIT  = 4'h7,
      FCS_OP_OTP_ENTER    = 4'h8,
      FCS_OP_OTP_EXIT     = 4'h9
   } fcs_op_e;

   typedef enum logic [4:0] {
      H_IDLE   = 5'b00001,
      H_WRITE  = 5'b00010,
      H_READ   = 5'b00100,
      H_POLL   = 5'b01000,
      H_RSTPIN = 5'b10000
   } fcs_host_state_e;

   typedef enum logic [5:0] {
      B_IDLE   = 6'b000001,
      B_WSET   = 6'b000010,
      B_WPULSE = 6'b000100,
      B_WHOLD  = 6'b001000,
      B_RACC   = 6'b010000,
      B_RSYNC  = 6'b100000
   } fcs_bus_state_e;
endpackage : fcs_pkg

// *** src/fcs_if.sv ***
// Purpose: Cycle request carrier between sequencer and pin cycle engine
// Assumes: Single clock domain
// Notes:   req is a level held until done
`timescale 1ns/1ps
`default_nettype none
interface fcs_if #(parameter int ADDR_W = 23);
   logic              req;
   logic              we;
   logic [ADDR_W-1:0] addr;
   logic [15:0]       wdata;
   logic              standby;
   logic              done;
   logic [15:0]       rdata;

   modport seq (output req, we, addr, wdata, standby, input done, rdata);
   modport cyc (input req, we, addr, wdata, standby, output done, rdata);
endinterface : fcs_if
`default_nettype wire

// *** src/fcs_bus_cycle.sv ***
// Purpose: Runs single read and write cycles on the flash pins
// Assumes: Device samples address and data on the rising write strobe
// Notes:   Chip select stays low between cycles so an open page survives
`timescale 1ns/1ps
`default_nettype none
`include "fcs_consts.svh"
module fcs_bus_cycle
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 23
)(
   input  wire logic              clk,
   input  wire logic              reset,
   fcs_if.cyc                     bus,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [15:0]            flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [15:0]       flash_dq_i,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n
);
   localparam int PW = ADDR_W - `FCS_PAGE_BITS;

   fcs_bus_state_e    st_q;
   logic [7:0]        cnt_q;
   logic [PW-1:0]     tag_q;
   logic              page_open_q;
   logic [15:0]       s1_q, s2_q, s3_q;
   logic [15:0]       rdata_q;
   logic [ADDR_W-1:0] addr_q;
   logic [15:0]       dq_q;
   logic              dq_oe_q, ce_n_q, oe_n_q, we_n_q;

   wire  page_hit = page_open_q &&
                    (bus.addr[ADDR_W-1:`FCS_PAGE_BITS] == tag_q);
   wire  cnt_zero = (cnt_q == 8'h00);
   wire  sync_ok  = cnt_zero && (s2_q == s3_q);

   // ----------------------------------------------------------------
   // Data input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      s1_q <= flash_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q        <= B_IDLE;
         cnt_q       <= 8'h00;
         page_open_q <= 1'b0;
         tag_q       <= '0;
         addr_q      <= '0;
         dq_q        <= 16'h0000;
         dq_oe_q     <= 1'b0;
         ce_n_q      <= 1'b1;
         oe_n_q      <= 1'b1;
         we_n_q      <= 1'b1;
         rdata_q     <= 16'h0000;
      end else begin
         unique case (st_q)
            B_IDLE: begin
               // Address is held while idle so the device can doze
               ce_n_q <= bus.standby;
               if (bus.standby)
                  page_open_q <= 1'b0;
               if (bus.req && !bus.standby) begin
                  addr_q <= bus.addr;
                  ce_n_q <= 1'b0;
                  if (bus.we) begin
                     dq_q        <= bus.wdata;
                     dq_oe_q     <= 1'b1;
                     page_open_q <= 1'b0;
                     st_q        <= B_WSET;
                  end else begin
                     oe_n_q <= 1'b0;
                     cnt_q  <= page_hit ? 8'(`FCS_PAGE_CYC - 1)
                                        : 8'(`FCS_RANDOM_CYC - 1);
                     st_q   <= B_RACC;
                  end
               end
            end
            B_WSET: begin
               we_n_q <= 1'b0;
               cnt_q  <= 8'(`FCS_WE_CYC - 1);
               st_q   <= B_WPULSE;
            end
            B_WPULSE: begin
               if (cnt_zero) begin
                  we_n_q <= 1'b1;
                  st_q   <= B_WHOLD;
               end else
                  cnt_q <= cnt_q - 8'h01;
            end
            B_WHOLD: begin
               dq_oe_q <= 1'b0;
               st_q    <= B_IDLE;
            end
            B_RACC: begin
               if (cnt_zero) begin
                  cnt_q <= 8'(`FCS_SYNC_CYC - 1);
                  st_q  <= B_RSYNC;
               end else
                  cnt_q <= cnt_q - 8'h01;
            end
            B_RSYNC: begin
               if (!cnt_zero)
                  cnt_q <= cnt_q - 8'h01;
               else if (sync_ok) begin
                  rdata_q     <= s3_q;
                  oe_n_q      <= 1'b1;
                  tag_q       <= addr_q[ADDR_W-1:`FCS_PAGE_BITS];
                  page_open_q <= 1'b1;
                  st_q        <= B_IDLE;
               end
            end
         endcase
      end
   end

   assign bus.done    = (st_q == B_WHOLD) || ((st_q == B_RSYNC) && sync_ok);
   assign bus.rdata   = (st_q == B_RSYNC) ? s3_q : rdata_q;
   assign flash_addr  = addr_q;
   assign flash_dq_o  = dq_q;
   assign flash_dq_oe = dq_oe_q;
   assign flash_ce_n  = ce_n_q;
   assign flash_oe_n  = oe_n_q;
   assign flash_we_n  = we_n_q;
endmodule : fcs_bus_cycle
`default_nettype wire

// *** src/fcs_host.sv ***
// Purpose: Host controller that drives a parallel NOR flash by its pins
// Assumes: Device keeps its own command state machine and protection
// Notes:   Program and erase run in the background; status is polled
//
// How it works
// - Every command but read goes out as plain write strobe cycles.
// - Bypass programming takes two writes, normal programming four.
// - The secured region is reached by its entry and exit sequences.
// - A standby request lifts chip select while idle.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_consts.svh"
module fcs_host
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 23
)(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire logic [3:0]        cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [15:0]       cmd_data,
   output logic                   rsp_valid,
   output logic                   rsp_err,
   output logic [15:0]            rsp_data,
   output logic                   op_done,
   output logic                   busy,
   output logic                   suspended,
   output logic                   bypass_mode,
   output logic                   otp_mode,
   input  wire logic              standby_req,
   input  wire logic              hw_reset_req,
   input  wire logic              supply_ok,
   input  wire logic              ready_busy_output,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [15:0]            flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [15:0]       flash_dq_i,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic                   flash_reset_n
);
   localparam int BB = `FCS_BANK_BITS;

   fcs_if #(.ADDR_W(ADDR_W)) bif ();

   fcs_host_state_e   state_q;
   fcs_op_e           op_q;
   logic [ADDR_W-1:0] addr_q, busy_addr_q;
   logic [15:0]       data_q, rsp_data_q;
   logic [2:0]        step_q;
   logic [7:0]        rst_cnt_q;
   logic              busy_q, susp_q, nested_q, bypass_q, otp_q;
   logic              tog_q, tog_seen_q;
   logic              rsp_valid_q, rsp_err_q, op_done_q;
   logic [1:0]        in_raw, in_clean;

   // ----------------------------------------------------------------
   // Command sequence tables
   // ----------------------------------------------------------------
   function automatic logic [2:0] seq_len(fcs_op_e op, logic byp);
      unique case (op)
         FCS_OP_PROGRAM:      seq_len = byp ? 3'd2 : 3'd4;
         FCS_OP_ERASE:        seq_len = 3'd6;
         FCS_OP_BYPASS_ENTER: seq_len = 3'd3;
         FCS_OP_OTP_ENTER:    seq_len = 3'd3;
         FCS_OP_BYPASS_EXIT:  seq_len = 3'd2;
         FCS_OP_OTP_EXIT:     seq_len = 3'd4;
         default:             seq_len = 3'd1;
      endcase
   endfunction : seq_len

   function automatic logic [ADDR_W+15:0] seq_word(
      fcs_op_e op, logic [2:0] step, logic byp,
      logic [ADDR_W-1:0] a, logic [15:0] d);
      logic [ADDR_W-1:0] u1;
      logic [ADDR_W-1:0] u2;
      logic              unlock;
      u1 = {{(ADDR_W-12){1'b0}}, `FCS_UNLOCK_A1};
      u2 = {{(ADDR_W-12){1'b0}}, `FCS_UNLOCK_A2};
      unlock = !(op == FCS_OP_PROGRAM && byp) && seq_len(op, byp) > 3'd2;
      seq_word = {a, d};
      if (unlock && step == 3'd0)
         seq_word = {u1, `FCS_D_UNLOCK1};
      else if (unlock && step == 3'd1)
         seq_word = {u2, `FCS_D_UNLOCK2};
      else
         unique case (op)
            FCS_OP_PROGRAM:
               if (step == (byp ? 3'd0 : 3'd2))
                  seq_word = {u1, `FCS_D_PROGRAM};
            FCS_OP_ERASE:
               if (step == 3'd2)
                  seq_word = {u1, `FCS_D_ERASE_SETUP};
               else if (step == 3'd3)
                  seq_word = {u1, `FCS_D_UNLOCK1};
               else if (step == 3'd4)
                  seq_word = {u2, `FCS_D_UNLOCK2};
               else
                  seq_word = {a, `FCS_D_SECTOR_ERS};
            FCS_OP_SUSPEND:      seq_word = {a, `FCS_D_SUSPEND};
            FCS_OP_RESUME:       seq_word = {a, `FCS_D_RESUME};
            FCS_OP_RESET:        seq_word = {a, `FCS_D_RESET};
            FCS_OP_BYPASS_ENTER: seq_word = {u1, `FCS_D_BYPASS};
            FCS_OP_OTP_ENTER:    seq_word = {u1, `FCS_D_OTP_ENTER};
            FCS_OP_BYPASS_EXIT,
            FCS_OP_OTP_EXIT:
               seq_word = (step == seq_len(op, byp) - 3'd1) ?
                          {a, `FCS_D_EXIT2} :
                          ((step == 3'd2 || op == FCS_OP_BYPASS_EXIT) ?
                           {(op == FCS_OP_OTP_EXIT ? u1 : a), `FCS_D_EXIT1} :
                           {a, d});
            default:             seq_word = {a, d};
         endcase
   endfunction : seq_word

   // ----------------------------------------------------------------
   // Pin input synchronisers
   // ----------------------------------------------------------------
   assign in_raw = {supply_ok, ready_busy_output};
   genvar g;
   for (g = 0; g < 2; g++) begin : g_sync
      logic [2:0] sh_q;
      logic       cln_q;
      always_ff @(posedge clk) begin
         if (reset) begin
            sh_q  <= 3'h0;
            cln_q <= 1'b0;
         end else begin
            sh_q <= {sh_q[1:0], in_raw[g]};
            if (sh_q[1] == sh_q[2])
               cln_q <= sh_q[2];
         end
      end
      assign in_clean[g] = cln_q;
   end
   wire supply_good = in_clean[1];
   wire rb_ready    = in_clean[0];

   // ----------------------------------------------------------------
   // Decode and acceptance
   // ----------------------------------------------------------------
   fcs_op_e cmd_e;
   assign cmd_e = fcs_op_e'(cmd_op);
   wire is_pe      = (cmd_e == FCS_OP_PROGRAM) || (cmd_e == FCS_OP_ERASE);
   wire bank_hit   = cmd_addr[ADDR_W-1 -: BB] == busy_addr_q[ADDR_W-1 -: BB];
   wire refuse     = !supply_good
                   || (is_pe && busy_q && !susp_q && bank_hit)
                   || (is_pe && nested_q)
                   || (cmd_e == FCS_OP_ERASE && susp_q)
                   || (cmd_e == FCS_OP_SUSPEND && (!busy_q || susp_q))
                   || (cmd_e == FCS_OP_RESUME && !susp_q)
                   || (cmd_op > 4'h9);
   wire idle       = (state_q == H_IDLE);
   wire take       = idle && cmd_valid && !hw_reset_req;
   wire poll_due   = busy_q && (!susp_q || nested_q);
   wire poll_go    = idle && !cmd_valid && !hw_reset_req && poll_due;
   wire [ADDR_W+15:0] wr_word = seq_word(op_q, step_q, bypass_q, addr_q,
                                         data_q);
   wire last_step  = step_q == seq_len(op_q, bypass_q) - 3'd1;
   wire wr_end     = (state_q == H_WRITE) && bif.done && last_step;
   wire poll_end   = (state_q == H_POLL) && bif.done;
   wire tog_now    = bif.rdata[`FCS_TOGGLE_BIT];
   wire settled    = tog_seen_q && (tog_now == tog_q) && rb_ready;

   assign bif.req     = (state_q == H_WRITE) || (state_q == H_READ) ||
                        (state_q == H_POLL);
   assign bif.we      = (state_q == H_WRITE);
   assign bif.addr    = (state_q == H_POLL) ? busy_addr_q :
                        (state_q == H_READ) ? addr_q : wr_word[ADDR_W+15:16];
   assign bif.wdata   = wr_word[15:0];
   assign bif.standby = standby_req && idle && !cmd_valid;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q   <= H_IDLE;
         op_q      <= FCS_OP_READ;
         addr_q    <= '0;
         data_q    <= 16'h0000;
         step_q    <= 3'd0;
         rst_cnt_q <= 8'h00;
      end else begin
         unique case (state_q)
            H_IDLE: begin
               if (hw_reset_req) begin
                  state_q   <= H_RSTPIN;
                  rst_cnt_q <= 8'(`FCS_RESET_CYC - 1);
               end else if (take && !refuse) begin
                  op_q    <= cmd_e;
                  addr_q  <= cmd_addr;
                  data_q  <= cmd_data;
                  step_q  <= 3'd0;
                  state_q <= (cmd_e == FCS_OP_READ) ? H_READ : H_WRITE;
               end else if (poll_go)
                  state_q <= H_POLL;
            end
            H_WRITE: begin
               if (bif.done) begin
                  step_q <= step_q + 3'd1;
                  if (last_step)
                     state_q <= H_IDLE;
               end
            end
            H_READ, H_POLL: begin
               if (bif.done)
                  state_q <= H_IDLE;
            end
            H_RSTPIN: begin
               if (rst_cnt_q == 8'h00)
                  state_q <= H_IDLE;
               else
                  rst_cnt_q <= rst_cnt_q - 8'h01;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Device mode tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || state_q == H_RSTPIN) begin
         busy_q      <= 1'b0;
         busy_addr_q <= '0;
         susp_q      <= 1'b0;
         nested_q    <= 1'b0;
         bypass_q    <= 1'b0;
         otp_q       <= 1'b0;
         tog_q       <= 1'b0;
         tog_seen_q  <= 1'b0;
      end else if (wr_end) begin
         unique case (op_q)
            FCS_OP_PROGRAM, FCS_OP_ERASE: begin
               tog_seen_q <= 1'b0;
               if (susp_q)
                  nested_q <= 1'b1;
               else begin
                  busy_q      <= 1'b1;
                  busy_addr_q <= addr_q;
               end
            end
            FCS_OP_SUSPEND:      susp_q <= 1'b1;
            FCS_OP_RESUME: begin
               susp_q     <= 1'b0;
               tog_seen_q <= 1'b0;
            end
            FCS_OP_BYPASS_ENTER: bypass_q <= 1'b1;
            FCS_OP_BYPASS_EXIT:  bypass_q <= 1'b0;
            FCS_OP_OTP_ENTER:    otp_q <= 1'b1;
            FCS_OP_OTP_EXIT:     otp_q <= 1'b0;
            default:             tog_seen_q <= tog_seen_q;
         endcase
      end else if (poll_end) begin
         if (settled) begin
            tog_seen_q <= 1'b0;
            if (nested_q)
               nested_q <= 1'b0;
            else
               busy_q <= 1'b0;
         end else begin
            tog_q      <= tog_now;
            tog_seen_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Answers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid_q <= 1'b0;
         rsp_err_q   <= 1'b0;
         rsp_data_q  <= 16'h0000;
         op_done_q   <= 1'b0;
      end else begin
         rsp_valid_q <= (take && refuse) || wr_end ||
                        ((state_q == H_READ) && bif.done);
         rsp_err_q   <= take && refuse;
         op_done_q   <= poll_end && settled;
         if ((state_q == H_READ) && bif.done)
            rsp_data_q <= bif.rdata;
      end
   end

   fcs_bus_cycle #(.ADDR_W(ADDR_W)) u_cyc (
      .clk         (clk),
      .reset       (reset),
      .bus         (bif),
      .flash_addr  (flash_addr),
      .flash_dq_o  (flash_dq_o),
      .flash_dq_oe (flash_dq_oe),
      .flash_dq_i  (flash_dq_i),
      .flash_ce_n  (flash_ce_n),
      .flash_oe_n  (flash_oe_n),
      .flash_we_n  (flash_we_n)
   );

   assign cmd_ready     = idle && !hw_reset_req;
   assign rsp_valid     = rsp_valid_q;
   assign rsp_err       = rsp_err_q;
   assign rsp_data      = rsp_data_q;
   assign op_done       = op_done_q;
   assign busy          = busy_q;
   assign suspended     = susp_q;
   assign bypass_mode   = bypass_q;
   assign otp_mode      = otp_q;
   // Slow reset pulse keeps the device out of any half-written sequence
   assign flash_reset_n = (state_q != H_RSTPIN);
endmodule : fcs_host
`default_nettype wire

// *** bench/fcs_host_checker.sv ***
// Purpose: Pin and handshake checks on fcs_host
// Assumes: One clock, synchronous reset
// Notes:   Bound below the module
`timescale 1ns/1ps
`default_nettype none
module fcs_host_checker #(parameter int ADDR_W = 23) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              cmd_valid,
   input wire logic              cmd_ready,
   input wire logic              supply_ok,
   input wire logic              rsp_valid,
   input wire logic              rsp_err,
   input wire logic              op_done,
   input wire logic              busy,
   input wire logic              flash_dq_oe,
   input wire logic              flash_oe_n,
   input wire logic              flash_we_n,
   input wire logic              flash_reset_n,
   input wire logic [ADDR_W-1:0] flash_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_we_drives_dq: assert property (
      !flash_we_n |-> flash_dq_oe) else $error("strobe without data");
   a_no_rw_clash: assert property (
      flash_we_n || flash_oe_n) else $error("read and write together");
   a_we_width: assert property (
      $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n) else $error("width");
   a_addr_hold: assert property (
      !flash_we_n |-> $stable(flash_addr)) else $error("address moved");
   // Synced supply lags the pin by four edges, so five low samples are needed
   a_low_supply: assert property (
      (!supply_ok)[*5] ##0 (cmd_valid && cmd_ready) |=> rsp_valid && rsp_err)
      else $error("command taken on low supply");
   a_refuse_quiet: assert property (
      rsp_valid && rsp_err |-> flash_we_n && $past(flash_we_n))
      else $error("refused command reached pins");
   a_reset_width: assert property (
      $fell(flash_reset_n) |-> ##19 !flash_reset_n ##1 flash_reset_n)
      else $error("reset pulse width");
   a_done_busy: assert property (
      op_done |-> $past(busy)) else $error("done while idle");
endmodule : fcs_host_checker
bind fcs_host fcs_host_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// *** bench/fcs_flash_model.sv ***
// Purpose: Behavioural flash seen from its pins
// Assumes: Strobes are clock aligned
// Notes:   64 words; busy time shortened by parameter
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(parameter int BUSY_CYC = 60) (
   input  wire logic        clk,
   input  wire logic        flash_ce_n,
   input  wire logic        flash_oe_n,
   input  wire logic        flash_we_n,
   input  wire logic [22:0] flash_addr,
   input  wire logic [15:0] flash_dq_o,
   output logic      [15:0] flash_dq_i,
   output logic             ready_busy_output
);
   logic [15:0] mem [64];
   logic [15:0] h1_q = '0, last_q = '0;
   logic [1:0]  bank_q = '0;
   logic        we_q = 1'h1, oe_q = 1'h1, tog_q = 1'h0;
   int          cnt_q = 0;
   wire  [15:0] word = mem[flash_addr[5:0]];
   wire         stat = cnt_q != 0 && flash_addr[22:21] == bank_q;
   initial for (int i = 0; i < 64; i++) mem[i] = 16'h1000 + 16'(i);
   assign ready_busy_output = cnt_q == 0;
   // Released bus shows the inverse of the last word, never a held value
   assign flash_dq_i = flash_oe_n ? ~last_q : stat ?
      {8'h00, ~word[7], tog_q, 6'h00} : word;
   always @(posedge clk) begin
      we_q <= flash_we_n;
      oe_q <= flash_oe_n;
      if (!flash_oe_n) last_q <= flash_dq_i;
      if (oe_q && !flash_oe_n) tog_q <= ~tog_q;
      if (cnt_q != 0) cnt_q <= cnt_q - 1;
      if (!we_q && flash_we_n && !flash_ce_n) begin
         h1_q <= flash_dq_o;
         if (h1_q == 16'h00A0) begin
            mem[flash_addr[5:0]] <= flash_dq_o;
            bank_q <= flash_addr[22:21];
            cnt_q <= BUSY_CYC;
         end
         if (flash_dq_o == 16'h0030 && h1_q == 16'h0055) cnt_q <= BUSY_CYC;
      end
   end
endmodule : fcs_flash_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: Directed test of fcs_host against the flash model
// Assumes: Model stays busy across two commands
// Notes:   Bank 0 near 0, bank 2 at 400000
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, reset = 1, cmd_valid = 0, standby_req = 0, hw_reset_req = 0;
   logic supply_ok = 0, cmd_ready, rsp_valid, rsp_err, op_done, busy;
   logic suspended, bypass_mode, otp_mode, ready_busy_output, flash_dq_oe;
   logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
   logic [3:0]  cmd_op = '0;
   logic [22:0] cmd_addr = '0, flash_addr;
   logic [15:0] cmd_data = '0, rsp_data, flash_dq_o, flash_dq_i, rd;
   // Entry: suspended, otp mode, op code, refusal expected
   logic [6:0]  seq [10] = '{7'h0E, 7'h04, 7'h46, 7'h47, 7'h70, 7'h52,
                             7'h08, 7'h09, 7'h0A, 7'h17};
   int          failures = 0, checked = 0, n;
   always #12.5 clk = ~clk;
   fcs_host dut (.*);
   fcs_flash_model fm (.*);
   task automatic chk(input string s, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int lim);
      @(posedge clk);
      #1;
      if (++n > lim) begin
         chk("wait bound", 16'h0001, 16'h0000);
         report_and_stop();
      end
   endtask : tick
   task automatic c(input logic [3:0] o, input logic [22:0] a,
                    input logic [15:0] d, input logic e);
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_op <= o;
      cmd_addr <= a;
      cmd_data <= d;
      #1;
      n = 0;
      while (cmd_ready !== 1'h1) tick(300);
      @(posedge clk);
      cmd_valid <= 1'h0;
      #1;
      while (rsp_valid !== 1'h1) tick(600);
      chk("refusal", {15'h0, e}, {15'h0, rsp_err});
      rd = rsp_data;
   endtask : c
   task automatic rdchk(input logic [22:0] a, input logic [15:0] e);
      c(4'h0, a, 16'h0, 1'h0);
      chk("read data", e, rd);
   endtask : rdchk
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      repeat (4) @(posedge clk);
      c(4'h1, 23'h5, 16'h1234, 1'h1);
      @(posedge clk);
      supply_ok <= 1'h1;
      repeat (8) @(posedge clk);
      rdchk(23'h5, 16'h1005);
      chk("random cycles", 16'h0007, 16'(n));
      rdchk(23'h6, 16'h1006);
      chk("page cycles", 16'h0005, 16'(n));
      c(4'h1, 23'h5, 16'h1234, 1'h0);
      chk("program cycles", 16'h0014, 16'(n));
      c(4'h1, 23'h6, 16'h0001, 1'h1);
      rdchk(23'h400007, 16'h1007);
      n = 0;
      while (op_done !== 1'h1) tick(3000);
      rdchk(23'h5, 16'h1234);
      c(4'h6, 23'h0, 16'h0, 1'h0);
      c(4'h1, 23'h9, 16'h55AA, 1'h0);
      chk("bypass cycles", 16'h000A, 16'(n));
      n = 0;
      while (op_done !== 1'h1) tick(3000);
      rdchk(23'h9, 16'h55AA);
      for (int i = 0; i < 10; i++) begin
         c(seq[i][4:1], 23'h0, 16'h0, seq[i][0]);
         chk("susp", {15'h0, seq[i][6]}, {15'h0, suspended});
         chk("otp", {15'h0, seq[i][5]}, {15'h0, otp_mode});
      end
      c(4'h6, 23'h0, 16'h0, 1'h0);
      chk("bypass entered", 16'h0001, {15'h0, bypass_mode});
      @(posedge clk);
      hw_reset_req <= 1'h1;
      n = 0;
      while (flash_reset_n !== 1'h0) tick(50);
      @(posedge clk);
      hw_reset_req <= 1'h0;
      repeat (24) tick(99);
      chk("bypass after reset", 16'h0, {15'h0, bypass_mode});
      @(posedge clk);
      standby_req <= 1'h1;
      repeat (4) tick(99);
      chk("standby select", 16'h1, {15'h0, flash_ce_n});
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
